/* File: hdm_pkg.sv */
// Purpose: Shared constants and types of the harmonic distortion monitor.
// Assumes: 100 MHz clock, magnitudes unsigned, thresholds in 0.01 % units.
// Notes:   All fixed-point scale factors live here.
package hdm_pkg;
    // ----------------------------------------------------------------------
    // Spectrum and channels
    // ----------------------------------------------------------------------
    localparam int MAG_W      = 16;
    localparam int HARM_W     = 5;
    localparam int NUM_CHAN   = 5;
    localparam int ACC_W      = 40;
    localparam int WIDE_W     = 100;
    localparam logic [HARM_W-1:0] HARM_FUND = 5'h01;
    localparam logic [HARM_W-1:0] HARM_LAST = 5'h1f;
    localparam logic [2:0] CHAN_RES1  = 3'h3;
    localparam logic [2:0] CHAN_RES2  = 3'h4;
    localparam logic [2:0] CHAN_PH3   = 3'h2;

    // ----------------------------------------------------------------------
    // Settings, thresholds and scale factors
    // ----------------------------------------------------------------------
    localparam int THR_W = 14;
    localparam int DLY_W = 19;
    localparam logic [THR_W-1:0] THR_DEFAULT = 14'h03e8;
    localparam logic [THR_W-1:0] THR_MAX     = 14'h2710;
    localparam logic [DLY_W-1:0] DLY_DEFAULT = 19'h007d0;
    localparam logic [WIDE_W-1:0] SCALE_PCT  = 100'h2710;
    localparam logic [WIDE_W-1:0] SCALE_PCT2 = 100'h5f5e100;
    localparam logic [WIDE_W-1:0] SCALE_P_RL = 100'hf4240;
    localparam logic [WIDE_W-1:0] SCALE_A_RL = 100'he8d4a51000;
    localparam logic [WIDE_W-1:0] RESET_PCT  = 100'h61;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int DELAY_STEP_NS   = 5000000;
    localparam int STEP_CYCLES     = DELAY_STEP_NS / CLOCK_PERIOD_NS;

    typedef enum logic {HDM_AMPLITUDE = 1'b0, HDM_POWER = 1'b1} hdm_method_type;
    typedef enum logic {HDM_SIDE_FIRST = 1'b0, HDM_SIDE_SECOND = 1'b1} hdm_side_type;
    typedef enum logic [2:0] {
        HDM_IDLE    = 3'b001,
        HDM_START   = 3'b010,
        HDM_BLOCKED = 3'b100
    } hdm_state_type;

    typedef struct packed {
        logic [2:0]        chan;
        logic [HARM_W-1:0] harm;
        logic [MAG_W-1:0]  mag;
    } hdm_sample_type;

    typedef struct packed {
        logic [2:0]             enable;
        logic [2:0][THR_W-1:0]  thr;
        logic [2:0][DLY_W-1:0]  delay;
    } hdm_group_type;
endpackage

/* File: hdm_element.sv */
// Purpose: One alarm element: hysteresis pick-up, blocking and definite-time alarm.
// Assumes: Comparison flags and step tick come from the monitor top.
// Notes:   Delay counts in 5 ms steps; a zero delay alarms on the next edge.
module hdm_element
    import hdm_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             enable,
    input  wire logic             update,
    input  wire logic             over,
    input  wire logic             under,
    input  wire logic             block,
    input  wire logic             tick,
    input  wire logic [DLY_W-1:0] delay,
    output logic                  start,
    output logic                  alarm,
    output logic                  blocked
);
    logic          picked_ff;
    logic          nxt_picked;
    hdm_state_type state_ff;
    hdm_state_type nxt_state;
    logic [DLY_W-1:0] count_ff;
    logic [DLY_W-1:0] nxt_count;
    logic          alarm_ff;
    logic          nxt_alarm;

    // ----------------------------------------------------------------------
    // Pick-up with hysteresis
    // ----------------------------------------------------------------------
    // Between the pick-up and release levels the element holds its state.
    assign nxt_picked = !enable ? 1'b0 :
                        (update && over) ? 1'b1 :
                        (update && under) ? 1'b0 :
                        picked_ff;

    always_comb begin
        case (state_ff)
            HDM_IDLE, HDM_START, HDM_BLOCKED: begin
                if (!nxt_picked) begin
                    nxt_state = HDM_IDLE;
                end else if (block) begin
                    nxt_state = HDM_BLOCKED;
                end else begin
                    nxt_state = HDM_START;
                end
            end
            default: nxt_state = HDM_IDLE;
        endcase
    end

    // ----------------------------------------------------------------------
    // Definite-time alarm
    // ----------------------------------------------------------------------
    assign nxt_count = (nxt_state != HDM_START) ? '0 :
                       (tick && count_ff < delay) ? count_ff + 1'b1 : count_ff;
    assign nxt_alarm = (nxt_state == HDM_START) && (nxt_count >= delay);

    always_ff @(posedge clock) begin
        if (srst) begin
            picked_ff <= 1'b0;
            state_ff  <= HDM_IDLE;
            count_ff  <= '0;
            alarm_ff  <= 1'b0;
        end else begin
            picked_ff <= nxt_picked;
            state_ff  <= nxt_state;
            count_ff  <= nxt_count;
            alarm_ff  <= nxt_alarm;
        end
    end

    assign start   = (state_ff == HDM_START);
    assign blocked = (state_ff == HDM_BLOCKED);
    assign alarm   = alarm_ff;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_disabled_quiet: assert property (!enable |=> !start && !alarm && !blocked)
        else $error("Disabled element is active.");
    a_block_no_start: assert property (blocked |-> !start && !alarm)
        else $error("Blocked element shows start or alarm.");
    a_start_cause: assert property (enable && update && over && !block |=> start)
        else $error("Pick-up without block did not start.");
    a_alarm_delay: assert property ($rose(alarm) |-> start && count_ff >= delay)
        else $error("Alarm raised before delay elapsed.");
    a_release_level: assert property ($fell(picked_ff) |-> $past(!enable || (update && under)))
        else $error("Pick-up released above reset level.");
endmodule

/* File: hdm_monitor.sv */
// Purpose: Total harmonic distortion monitor for three phase and two residual currents.
// Assumes: Spectra arrive serially, harmonic index 1 to 31 in rising order per channel.
// Notes:   Ratios are compared by cross-multiplication, so no divider or root is built.
module hdm_monitor
    import hdm_pkg::*;
#(
    parameter int STEP_CNT = STEP_CYCLES
)
(
    input  wire logic           clock,
    input  wire logic           srst,
    input  wire hdm_sample_type spec_first,
    input  wire logic           spec_first_valid,
    input  wire hdm_sample_type spec_second,
    input  wire logic           spec_second_valid,
    input  wire logic           static_we,
    input  wire hdm_side_type   static_side,
    input  wire hdm_method_type static_method,
    input  wire logic           group_we,
    input  wire hdm_group_type  group_set,
    input  wire logic [2:0]     block_in,
    output hdm_side_type        source_side_select,
    output hdm_method_type      method,
    output logic [2:0]          start,
    output logic [2:0]          alarm,
    output logic [2:0]          blocked
);
    // ----------------------------------------------------------------------
    // Settings
    // ----------------------------------------------------------------------
    hdm_side_type   side_ff;
    hdm_method_type method_ff;
    hdm_group_type  group_ff;
    hdm_group_type  group_dflt;

    assign group_dflt.enable = 3'h7;
    assign group_dflt.thr    = {THR_DEFAULT, THR_DEFAULT, THR_DEFAULT};
    assign group_dflt.delay  = {DLY_DEFAULT, DLY_DEFAULT, DLY_DEFAULT};

    // Only reset and an explicit static write touch side and method.
    always_ff @(posedge clock) begin
        if (srst) begin
            side_ff   <= HDM_SIDE_FIRST;
            method_ff <= HDM_AMPLITUDE;
        end else if (static_we) begin
            side_ff   <= static_side;
            method_ff <= static_method;
        end
    end

    // Group thresholds above 100.00 % are clipped to the upper limit; enables and delays pass unchanged.
    hdm_group_type group_clip;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_clip
            assign group_clip.thr[gi] = (group_set.thr[gi] > THR_MAX) ? THR_MAX : group_set.thr[gi];
        end
    endgenerate
    assign group_clip.enable = group_set.enable;
    assign group_clip.delay  = group_set.delay;

    always_ff @(posedge clock) begin
        if (srst) begin
            group_ff <= group_dflt;
        end else if (group_we) begin
            group_ff <= group_clip;
        end
    end

    assign source_side_select = side_ff;
    assign method             = method_ff;

    // ----------------------------------------------------------------------
    // Spectrum accumulation
    // ----------------------------------------------------------------------
    hdm_sample_type   smp;
    logic             smp_valid;
    logic [ACC_W-1:0] sum_ff  [NUM_CHAN];
    logic [ACC_W-1:0] fund_ff [NUM_CHAN];
    logic [ACC_W-1:0] mag_sq;
    logic [ACC_W-1:0] cur_sum;
    logic             chan_ok;
    logic             last_harm;

    assign smp       = (side_ff == HDM_SIDE_FIRST) ? spec_first : spec_second;
    assign smp_valid = (side_ff == HDM_SIDE_FIRST) ? spec_first_valid : spec_second_valid;
    assign chan_ok   = smp_valid && (smp.chan <= CHAN_RES2);
    assign mag_sq    = ACC_W'(smp.mag) * ACC_W'(smp.mag);
    assign cur_sum   = sum_ff[smp.chan] + mag_sq;
    assign last_harm = chan_ok && (smp.harm == HARM_LAST);

    // The fundamental restarts the harmonic sum, so a lost tail never mixes frames.
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                sum_ff[i]  <= '0;
                fund_ff[i] <= '0;
            end
        end else if (chan_ok && smp.harm == HARM_FUND) begin
            fund_ff[smp.chan] <= mag_sq;
            sum_ff[smp.chan]  <= '0;
        end else if (chan_ok && smp.harm > HARM_FUND) begin
            sum_ff[smp.chan]  <= cur_sum;
        end
    end

    // ----------------------------------------------------------------------
    // Threshold comparison
    // ----------------------------------------------------------------------
    logic [THR_W-1:0]  thr_sel;
    logic [WIDE_W-1:0] w_sum;
    logic [WIDE_W-1:0] w_fund;
    logic [WIDE_W-1:0] w_thr;
    logic [WIDE_W-1:0] w_rthr;
    logic              over_now;
    logic              under_now;
    logic [NUM_CHAN-1:0] over_ff;
    logic [NUM_CHAN-1:0] under_ff;
    logic [NUM_CHAN-1:0] done_ff;

    assign thr_sel = (smp.chan == CHAN_RES1) ? group_ff.thr[1] :
                     (smp.chan == CHAN_RES2) ? group_ff.thr[2] : group_ff.thr[0];
    assign w_sum   = WIDE_W'(cur_sum);
    assign w_fund  = WIDE_W'(fund_ff[smp.chan]);
    assign w_thr   = WIDE_W'(thr_sel);
    assign w_rthr  = w_thr * RESET_PCT;

    // Amplitude mode squares the threshold instead of rooting the ratio.
    assign over_now  = (method_ff == HDM_POWER) ?
                       (w_sum * SCALE_PCT > w_thr * w_fund) :
                       (w_sum * SCALE_PCT2 > w_thr * w_thr * w_fund);
    assign under_now = (method_ff == HDM_POWER) ?
                       (w_sum * SCALE_P_RL < w_rthr * w_fund) :
                       (w_sum * SCALE_A_RL < w_rthr * w_rthr * w_fund);

    always_ff @(posedge clock) begin
        if (srst) begin
            over_ff  <= '0;
            under_ff <= '1;
            done_ff  <= '0;
        end else begin
            done_ff <= '0;
            if (last_harm) begin
                over_ff[smp.chan]  <= over_now;
                under_ff[smp.chan] <= under_now;
                done_ff[smp.chan]  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Delay step tick
    // ----------------------------------------------------------------------
    logic [31:0] div_ff;
    logic        tick;

    assign tick = (div_ff == 32'(STEP_CNT - 1));
    always_ff @(posedge clock) begin
        if (srst || tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 32'h1;
        end
    end

    // ----------------------------------------------------------------------
    // Alarm elements
    // ----------------------------------------------------------------------
    logic [2:0] el_over;
    logic [2:0] el_under;
    logic [2:0] el_update;

    assign el_over   = {over_ff[4], over_ff[3], |over_ff[2:0]};
    assign el_under  = {under_ff[4], under_ff[3], &under_ff[2:0]};
    assign el_update = {done_ff[4], done_ff[3], |done_ff[2:0]};

    generate
        for (gi = 0; gi < 3; gi++) begin : g_el
            hdm_element u_el (
                .clock   (clock),
                .srst    (srst),
                .enable  (group_ff.enable[gi]),
                .update  (el_update[gi]),
                .over    (el_over[gi]),
                .under   (el_under[gi]),
                .block   (block_in[gi]),
                .tick    (tick),
                .delay   (group_ff.delay[gi]),
                .start   (start[gi]),
                .alarm   (alarm[gi]),
                .blocked (blocked[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_static_hold: assert property (!static_we |=> $stable(method_ff) && $stable(side_ff))
        else $error("Static setting changed without static write.");
    a_group_apply: assert property (group_we |=> group_ff.enable == $past(group_set.enable))
        else $error("Group write not applied next cycle.");
    a_phase_any: assert property (last_harm && smp.chan <= CHAN_PH3 && over_now |=> el_over[0])
        else $error("Phase over-threshold not seen by phase element.");
    a_res_own: assert property (last_harm && smp.chan == CHAN_RES1 |=> el_over[1] == $past(over_now))
        else $error("Residual element lost its own comparison.");
    a_thr_limit: assert property (group_ff.thr[0] <= THR_MAX && group_ff.thr[1] <= THR_MAX
                                  && group_ff.thr[2] <= THR_MAX)
        else $error("Threshold above upper limit.");
    a_hyst_gap: assert property (last_harm && over_now |-> !under_now)
        else $error("Pick-up and release true together.");
endmodule

/* File: hdm_frontend_model.sv */
// Purpose: Spectrum front-end model: sends one channel frame per go pulse.
// Assumes: Inputs held by the bench for the whole frame.
// Notes:   Slots 1 to 31 carry fundamental and harmonics, slot 32 carries DC as harm 0.
module hdm_frontend_model
    import hdm_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              go,
    input  wire logic [2:0]        chan,
    input  wire logic [MAG_W-1:0]  fund,
    input  wire logic [MAG_W-1:0]  hmag,
    input  wire logic [HARM_W-1:0] hidx,
    output hdm_sample_type         spec,
    output logic                   valid,
    output logic                   busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] slot_ff;
    initial begin
        valid   = 1'b0;
        busy    = 1'b0;
        slot_ff = 6'h01;
        spec    = '0;
    end
    // --------------------------------------------------------------
    // Frame generator
    // --------------------------------------------------------------
    // Idle data is inverted every cycle, so a stale sample never looks real.
    always @(posedge clock) begin
        if (busy) begin
            valid     <= 1'b1;
            spec.chan <= chan;
            spec.harm <= slot_ff[4:0];
            spec.mag  <= (slot_ff == 6'h01) ? fund : ((slot_ff[4:0] == hidx) ? hmag : 16'h0000);
            slot_ff   <= slot_ff + 6'h01;
            busy      <= (slot_ff != 6'h20);
        end else begin
            valid   <= 1'b0;
            spec    <= ~spec;
            busy    <= go;
            slot_ff <= 6'h01;
        end
    end
endmodule

/* File: tb_harmonic_distortion_monitor.sv */
// Purpose: Self-checking bench of the harmonic distortion monitor.
// Assumes: Fundamental 1000, one harmonic carries all distortion.
// Notes:   STEP_CNT is 10, so one delay step lasts 10 cycles.
module tb_harmonic_distortion_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    import hdm_pkg::*;
    logic              clock = 1'b0;
    logic              srst = 1'b1;
    logic              static_we = 1'b0;
    hdm_side_type      static_side = HDM_SIDE_FIRST;
    hdm_method_type    static_method = HDM_AMPLITUDE;
    logic              group_we = 1'b0;
    hdm_group_type     group_set = '0;
    logic [2:0]        block_in = 3'h0;
    logic              go1 = 1'b0;
    logic              go2 = 1'b0;
    logic [2:0]        chan = 3'h0;
    logic [MAG_W-1:0]  hmag = 16'h0000;
    logic [HARM_W-1:0] hidx = 5'h1f;
    hdm_sample_type    spec1;
    hdm_sample_type    spec2;
    logic              v1;
    logic              v2;
    logic              b1;
    logic              b2;
    hdm_side_type      side_q;
    hdm_method_type    method_q;
    logic [2:0]        start;
    logic [2:0]        alarm;
    logic [2:0]        blocked;
    int                n_fail = 0;
    int                checks = 0;
    int                cycles = 0;

    always #5 clock = ~clock;

    hdm_frontend_model fe1 (.clock(clock), .go(go1), .chan(chan), .fund(16'h03e8), .hmag(hmag),
                            .hidx(hidx), .spec(spec1), .valid(v1), .busy(b1));
    hdm_frontend_model fe2 (.clock(clock), .go(go2), .chan(chan), .fund(16'h03e8), .hmag(hmag),
                            .hidx(hidx), .spec(spec2), .valid(v2), .busy(b2));
    hdm_monitor #(.STEP_CNT(10)) dut (
        .clock(clock), .srst(srst), .spec_first(spec1), .spec_first_valid(v1), .spec_second(spec2),
        .spec_second_valid(v2), .static_we(static_we), .static_side(static_side),
        .static_method(static_method), .group_we(group_we), .group_set(group_set), .block_in(block_in),
        .source_side_select(side_q), .method(method_q), .start(start), .alarm(alarm), .blocked(blocked));

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic stop_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One frame, then the flags two edges after the last harmonic have settled.
    task automatic step(input logic sd, input logic [2:0] c, input logic [15:0] h, input logic [8:0] exp);
        @(posedge clock);
        chan <= c;
        hmag <= h;
        go1  <= ~sd;
        go2  <= sd;
        @(posedge clock);
        go1 <= 1'b0;
        go2 <= 1'b0;
        // Busy rises only after this edge, so wait one more before polling it.
        @(posedge clock);
        while (b1 || b2) @(posedge clock);
        repeat (4) @(posedge clock);
        chk({start, alarm, blocked}, exp);
    endtask

    task automatic gw(input logic [2:0] en, input logic [13:0] t0, input logic [13:0] t1,
                      input logic [13:0] t2, input logic [18:0] d0);
        @(posedge clock);
        group_set <= {en, t2, t1, t0, 19'h00fff, 19'h00fff, d0};
        group_we  <= 1'b1;
        @(posedge clock);
        group_we <= 1'b0;
    endtask

    task automatic sw(input hdm_side_type sd, input hdm_method_type m);
        @(posedge clock);
        static_side   <= sd;
        static_method <= m;
        static_we     <= 1'b1;
        @(posedge clock);
        static_we <= 1'b0;
        @(posedge clock);
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            stop_test();
        end
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        chk({start, alarm, blocked}, 9'h000);
        chk({7'h00, side_q, method_q}, 9'h000);
        step(1'b0, 3'h1, 16'h0000, 9'h000);
        step(1'b0, 3'h2, 16'h0000, 9'h000);
        step(1'b0, 3'h0, 16'h0065, 9'h040);
        step(1'b0, 3'h0, 16'h0062, 9'h040);
        step(1'b0, 3'h0, 16'h0061, 9'h040);
        step(1'b0, 3'h1, 16'h0096, 9'h040);
        step(1'b0, 3'h1, 16'h0000, 9'h040);
        step(1'b0, 3'h0, 16'h0060, 9'h000);
        step(1'b0, 3'h2, 16'h0065, 9'h040);
        step(1'b0, 3'h2, 16'h0000, 9'h000);
        hidx <= 5'h02;
        step(1'b0, 3'h3, 16'h0065, 9'h080);
        step(1'b0, 3'h3, 16'h0000, 9'h000);
        gw(3'h7, 14'h03e8, 14'h07d0, 14'h01f4, 19'h00fff);
        step(1'b0, 3'h3, 16'h0096, 9'h000);
        step(1'b0, 3'h4, 16'h003c, 9'h100);
        chk({7'h00, side_q, method_q}, 9'h000);
        block_in <= 3'h4;
        repeat (3) @(posedge clock);
        chk({6'h00, start}, 9'h000);
        step(1'b0, 3'h4, 16'h0000, 9'h000);
        step(1'b0, 3'h4, 16'h003c, 9'h004);
        step(1'b0, 3'h4, 16'h0000, 9'h000);
        block_in <= 3'h0;
        sw(HDM_SIDE_FIRST, HDM_POWER);
        chk({7'h00, side_q, method_q}, 9'h001);
        step(1'b0, 3'h0, 16'h012c, 9'h000);
        step(1'b0, 3'h0, 16'h0140, 9'h040);
        step(1'b0, 3'h0, 16'h012c, 9'h000);
        sw(HDM_SIDE_SECOND, HDM_AMPLITUDE);
        chk({7'h00, side_q, method_q}, 9'h002);
        step(1'b0, 3'h0, 16'h0096, 9'h000);
        step(1'b1, 3'h0, 16'h0096, 9'h040);
        gw(3'h6, 14'h03e8, 14'h07d0, 14'h01f4, 19'h00fff);
        repeat (3) @(posedge clock);
        chk({start, alarm, blocked}, 9'h000);
        step(1'b1, 3'h0, 16'h00c8, 9'h000);
        chk({7'h00, side_q, method_q}, 9'h002);
        gw(3'h7, 14'h3fff, 14'h07d0, 14'h01f4, 19'h00003);
        step(1'b1, 3'h0, 16'h03e9, 9'h040);
        repeat (12) @(posedge clock);
        chk({start, alarm, blocked}, 9'h040);
        repeat (20) @(posedge clock);
        chk({start, alarm, blocked}, 9'h048);
        stop_test();
    end
endmodule
